/* File: logic/mfcs_ecc.sv */
`timescale 1ns/1ns
`default_nettype none
// Hamming (38,32) encoder and single-error corrector, purely combinational
// so that correction costs no read cycle.
module mfcs_ecc (
  mfcs_ecc_if.unit ecc
);
  // Code positions 1..38; powers of two hold check bits.
  function automatic logic [6:0] syndrome(input logic [31:0] d,
                                          input logic [6:0] c);
    logic [6:0] s;
    int         j;
    s = 7'h00;
    j = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[j]) begin
          s = s ^ 7'(p);
        end
        j++;
      end
    end
    // The seventh bit is a plain high-half parity, unused for correction.
    return {c[6] ^ ^d[31:16], s[5:0] ^ c[5:0]};
  endfunction

  logic [6:0] synd;

  // Encoding is the syndrome of the data against zero check bits.
  assign ecc.encCheck = syndrome(ecc.encData, 7'h00);
  assign synd         = syndrome(ecc.decRaw, ecc.decCheck);

  // Flip the one data bit the syndrome points to; double errors go unseen.
  always_comb begin
    int j;
    j = 0;
    ecc.decFixed = ecc.decRaw;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (synd[5:0] == 6'(p)) begin
          ecc.decFixed[j] = ~ecc.decRaw[j];
        end
        j++;
      end
    end
  end
endmodule : mfcs_ecc
`default_nettype wire

/* File: logic/mfcs_ecc_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Word and check code carried between the sequencer and its ECC unit.
interface mfcs_ecc_if;
  logic [31:0] encData;
  logic [6:0]  encCheck;
  logic [31:0] decRaw;
  logic [6:0]  decCheck;
  logic [31:0] decFixed;
  modport user (output encData, decRaw, decCheck, input encCheck, decFixed);
  modport unit (input encData, decRaw, decCheck, output encCheck, decFixed);
endinterface : mfcs_ecc_if
`default_nettype wire

/* File: logic/mfcs_pkg.sv */
`default_nettype none
package mfcs_pkg;
  // Access width field encodings.
  localparam logic [1:0] WIDTH_ROM  = 2'h2;
  localparam logic [1:0] WIDTH_PROG = 2'h1;
  // Command addresses, low 16 bits.
  localparam logic [15:0] ADDR_UNLOCK1 = 16'h1550;
  localparam logic [15:0] ADDR_UNLOCK2 = 16'h0aa8;
  // Command data codes, low 8 bits.
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'ha0;
  localparam logic [7:0] CODE_ERASE   = 8'h80;
  localparam logic [7:0] CODE_CHIP    = 8'h10;
  localparam logic [7:0] CODE_SECTOR  = 8'h30;
  localparam logic [7:0] CODE_RESET   = 8'hf0;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  // Check code width per 32-bit word.
  localparam int CHECK_BITS = 7;
  // Sector erase timeout window.
  localparam int CLOCK_HZ      = 25_000_000;
  localparam int TIMEOUT_US    = 35;
  localparam int TIMEOUT_TICKS = (TIMEOUT_US * (CLOCK_HZ / 1_000_000));
  // Decoder states, Gray coded along the unlock path.
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h0, SEQ_U1 = 4'h1, SEQ_U2 = 4'h3, SEQ_PROG = 4'h2,
    SEQ_ERA = 4'h6, SEQ_EU1 = 4'h7, SEQ_EU2 = 4'h5
  } mfcs_seq_type;
  typedef enum logic [2:0] {
    ALG_IDLE = 3'h0, ALG_WRITE = 3'h1, ALG_CHIP = 3'h3,
    ALG_WINDOW = 3'h2, ALG_SECTOR = 3'h6, ALG_SUSP = 3'h7
  } mfcs_alg_type;
endpackage : mfcs_pkg
`default_nettype wire

/* File: logic/mfcs_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Width field 10: ROM mode, 32-bit reads, fetch from array allowed.
// - Width field 01: programming mode, 16-bit access, commands on, no fetch.
// - Every reset release forces width field to 10, ROM mode.
// - ROM mode recognises no commands, starts nothing, alters no cells; a window opened in programming mode still starts sector erase.
// - Programming mode returns 16-bit half-words, refuses word reads.
// - Only low 8 data bits of command cycles are compared.
// - Only low 16 address bits decoded; upper bits must hit flash range.
// - Program: AA@1550, 55@AA8, A0@1550, then data at target.
// - Chip erase: six writes ending 10@1550, erases all sectors.
// - Sector erase: five chip-erase cycles then 30 at sector address.
// - Each write stores a 7-bit check code per 4 bytes.
// - Reads correct single-bit errors with no extra cycles.
// - Array reads have zero wait states up to 40 MHz.
// - Sector erase starts after 35 us window; more 30 writes add sectors.
// - Suspend only during sector erase or window; restart only suspended.
// - Read/reset keeps read state; also recovers from time-limit overrun.
module mfcs_sequencer #(
  parameter int ADDR_BITS    = 17,
  parameter int SECTOR_BITS  = 4,
  parameter int WINDOW_TICKS = mfcs_pkg::TIMEOUT_TICKS
) (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Width select write port.
  input  wire logic                   widthWrite,
  input  wire logic [1:0]             widthIn,
  output logic      [1:0]             access_width_field,
  output logic                        fetchAllowed,
  // CPU bus access.
  input  wire logic                   busValid,
  input  wire logic                   busWrite,
  input  wire logic                   busHalf,
  input  wire logic                   busInRange,
  input  wire logic [31:0]            busAddr,
  input  wire logic [15:0]            busWdata,
  output logic                        busError,
  output logic      [31:0]            busRdata,
  // Array port.
  input  wire logic [31:0]            arrayData,
  input  wire logic [6:0]             arrayCheck,
  output logic      [ADDR_BITS-3:0]   arrayIndex,
  // Embedded algorithm commands and status.
  output logic                        progStart,
  output logic      [ADDR_BITS-1:0]   program_target_address,
  output logic      [15:0]            program_half_word,
  output logic      [31:0]            progWord,
  output logic      [6:0]             progCheck,
  output logic                        chipEraseStart,
  output logic                        sectorEraseStart,
  output logic      [(1<<SECTOR_BITS)-1:0] sectorMask,
  output logic                        eraseSuspend,
  output logic                        eraseResume,
  input  wire logic                   algDone,
  input  wire logic                   algOverrun,
  output logic                        busy
);
  initial begin
    if (ADDR_BITS < 16 || ADDR_BITS > 32 || SECTOR_BITS >= ADDR_BITS ||
        WINDOW_TICKS < 1 || WINDOW_TICKS > 65536) begin
      $error("mfcs_sequencer: unsupported parameters");
    end
  end

  localparam int SHIFT = ADDR_BITS - SECTOR_BITS;

  mfcs_ecc_if eccBus ();
  mfcs_ecc    eccUnit (.ecc(eccBus));

  logic [1:0]                   next_width;
  mfcs_pkg::mfcs_seq_type       seq, next_seq;
  mfcs_pkg::mfcs_alg_type       alg, next_alg;
  logic [15:0]                  windowCnt, next_windowCnt;
  logic [(1<<SECTOR_BITS)-1:0]  next_sectorMask;
  logic                         hung, next_hung;
  logic [31:0]                  next_rdata;
  logic                         next_error;
  logic                         progMode, cmdWrite, isReset;
  logic [15:0]                  lowAddr;
  logic [7:0]                   code;

  // Match of one command cycle on low address bits and low data byte.
  function automatic logic hit(input logic [15:0] a, input logic [7:0] d,
                               input logic [15:0] ea, input logic [7:0] ed);
    return (a == ea) && (d == ed);
  endfunction

  assign progMode     = (access_width_field == mfcs_pkg::WIDTH_PROG);
  assign fetchAllowed = (access_width_field == mfcs_pkg::WIDTH_ROM);
  assign cmdWrite = busValid && busWrite && busHalf && busInRange && progMode;
  assign lowAddr = busAddr[15:0];
  assign code    = busWdata[7:0];
  assign isReset = cmdWrite && (code == mfcs_pkg::CODE_RESET);
  assign busy    = (alg != mfcs_pkg::ALG_IDLE) || hung;

  // ECC on the program word; the half-word sits in its lane, other half ones.
  assign eccBus.encData = busAddr[1] ? {busWdata, 16'hffff}
                                     : {16'hffff, busWdata};
  assign eccBus.decRaw   = arrayData;
  assign eccBus.decCheck = arrayCheck;
  assign arrayIndex      = busAddr[ADDR_BITS-1:2];

  // Width field next value.
  always_comb begin
    next_width = access_width_field;
    if (widthWrite) begin
      next_width = widthIn;
    end
  end

  // Command decoder next state.
  always_comb begin
    next_seq = seq;
    if (cmdWrite && alg == mfcs_pkg::ALG_IDLE && !hung) begin
      next_seq = mfcs_pkg::SEQ_IDLE;
      case (seq)
        mfcs_pkg::SEQ_IDLE: begin
          if (hit(lowAddr, code, mfcs_pkg::ADDR_UNLOCK1,
                  mfcs_pkg::CODE_UNLOCK1)) begin
            next_seq = mfcs_pkg::SEQ_U1;
          end
        end
        mfcs_pkg::SEQ_U1: begin
          if (hit(lowAddr, code, mfcs_pkg::ADDR_UNLOCK2,
                  mfcs_pkg::CODE_UNLOCK2)) begin
            next_seq = mfcs_pkg::SEQ_U2;
          end
        end
        mfcs_pkg::SEQ_U2: begin
          if (hit(lowAddr, code, mfcs_pkg::ADDR_UNLOCK1,
                  mfcs_pkg::CODE_PROGRAM)) begin
            next_seq = mfcs_pkg::SEQ_PROG;
          end else if (hit(lowAddr, code, mfcs_pkg::ADDR_UNLOCK1,
                           mfcs_pkg::CODE_ERASE)) begin
            next_seq = mfcs_pkg::SEQ_ERA;
          end
        end
        mfcs_pkg::SEQ_ERA: begin
          if (hit(lowAddr, code, mfcs_pkg::ADDR_UNLOCK1,
                  mfcs_pkg::CODE_UNLOCK1)) begin
            next_seq = mfcs_pkg::SEQ_EU1;
          end
        end
        mfcs_pkg::SEQ_EU1: begin
          if (hit(lowAddr, code, mfcs_pkg::ADDR_UNLOCK2,
                  mfcs_pkg::CODE_UNLOCK2)) begin
            next_seq = mfcs_pkg::SEQ_EU2;
          end
        end
        default: next_seq = mfcs_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Algorithm control next state.
  always_comb begin
    next_alg        = alg;
    next_windowCnt  = windowCnt;
    next_sectorMask = sectorMask;
    next_hung       = hung;
    progStart        = 1'b0;
    chipEraseStart   = 1'b0;
    sectorEraseStart = 1'b0;
    eraseSuspend     = 1'b0;
    eraseResume      = 1'b0;
    case (alg)
      mfcs_pkg::ALG_IDLE: begin
        if (hung) begin
          if (isReset) begin
            next_hung = 1'b0;
          end
        end else if (cmdWrite && seq == mfcs_pkg::SEQ_PROG) begin
          progStart = !busAddr[0];
          next_alg  = busAddr[0] ? mfcs_pkg::ALG_IDLE : mfcs_pkg::ALG_WRITE;
        end else if (cmdWrite && seq == mfcs_pkg::SEQ_EU2) begin
          if (hit(lowAddr, code, mfcs_pkg::ADDR_UNLOCK1,
                  mfcs_pkg::CODE_CHIP)) begin
            chipEraseStart  = 1'b1;
            next_sectorMask = '1;
            next_alg        = mfcs_pkg::ALG_CHIP;
          end else if (code == mfcs_pkg::CODE_SECTOR) begin
            next_sectorMask = '0;
            next_sectorMask[busAddr[ADDR_BITS-1:SHIFT]] = 1'b1;
            next_windowCnt  = 16'(WINDOW_TICKS - 1);
            next_alg        = mfcs_pkg::ALG_WINDOW;
          end
        end
      end
      mfcs_pkg::ALG_WINDOW: begin
        if (cmdWrite && code == mfcs_pkg::CODE_SECTOR) begin
          next_sectorMask[busAddr[ADDR_BITS-1:SHIFT]] = 1'b1;
        end
        if (cmdWrite && code == mfcs_pkg::CODE_SUSPEND) begin
          eraseSuspend = 1'b1;
          next_alg     = mfcs_pkg::ALG_SUSP;
        end else if (windowCnt == 16'h0000) begin
          sectorEraseStart = 1'b1;
          next_alg         = mfcs_pkg::ALG_SECTOR;
        end else begin
          next_windowCnt = windowCnt - 16'h0001;
        end
      end
      mfcs_pkg::ALG_SECTOR: begin
        if (cmdWrite && code == mfcs_pkg::CODE_SUSPEND) begin
          eraseSuspend = 1'b1;
          next_alg     = mfcs_pkg::ALG_SUSP;
        end else if (algDone || algOverrun) begin
          next_hung = algOverrun;
          next_alg  = mfcs_pkg::ALG_IDLE;
        end
      end
      mfcs_pkg::ALG_SUSP: begin
        if (cmdWrite && code == mfcs_pkg::CODE_SECTOR) begin
          eraseResume = 1'b1;
          next_alg    = mfcs_pkg::ALG_SECTOR;
        end
      end
      default: begin
        // Write and chip erase ignore every command until they finish.
        if (algDone || algOverrun) begin
          next_hung = algOverrun;
          next_alg  = mfcs_pkg::ALG_IDLE;
        end
      end
    endcase
  end

  // Read path and refusal of word reads in programming mode.
  always_comb begin
    next_error = 1'b0;
    next_rdata = busRdata;
    if (busValid && !busWrite) begin
      if (progMode) begin
        next_error = !busHalf;
        next_rdata = {16'h0000, busAddr[1] ? eccBus.decFixed[31:16]
                                           : eccBus.decFixed[15:0]};
      end else begin
        next_rdata = eccBus.decFixed;
      end
    end else if (busValid && busWrite && !cmdWrite) begin
      // writes outside programming mode are refused.
      next_error = !progMode;
    end
  end

  // All state registers; reset returns to ROM mode.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      access_width_field <= mfcs_pkg::WIDTH_ROM;
      seq        <= mfcs_pkg::SEQ_IDLE;
      alg        <= mfcs_pkg::ALG_IDLE;
      windowCnt  <= 16'h0000;
      sectorMask <= '0;
      hung       <= 1'b0;
      busRdata   <= 32'h0000_0000;
      busError   <= 1'b0;
      program_target_address <= '0;
      program_half_word      <= 16'h0000;
      progWord   <= 32'h0000_0000;
      progCheck  <= 7'h00;
    end else begin
      access_width_field <= next_width;
      seq        <= next_seq;
      alg        <= next_alg;
      windowCnt  <= next_windowCnt;
      sectorMask <= next_sectorMask;
      hung       <= next_hung;
      busRdata   <= next_rdata;
      busError   <= next_error;
      if (progStart) begin
        program_target_address <= busAddr[ADDR_BITS-1:0];
        program_half_word      <= busWdata;
        progWord   <= eccBus.encData;
        progCheck  <= eccBus.encCheck;
      end
    end
  end
endmodule : mfcs_sequencer
`default_nettype wire

/* File: verif/mfcs_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
// CPU core issuing one access per cycle; the array reads as a zero word until load,
// whose check code is zero too, so reads need no correction until then.
module mfcs_cpu_model (
  // Clock.
  input  wire logic   ref_clk,
  // Bus access.
  output logic        busValid,
  output logic        busWrite,
  output logic        busHalf,
  output logic        busInRange,
  output logic [31:0] busAddr,
  output logic [15:0] busWdata,
  // Array contents.
  output logic [31:0] arrayData,
  output logic [6:0]  arrayCheck
);
  // Idle from time zero so nothing is taken during reset.
  initial begin
    busValid = 1'b0;
    busWrite = 1'b0;
    busHalf = 1'b0;
    busInRange = 1'b0;
    busAddr = 32'h0;
    busWdata = 16'h0;
    arrayData = 32'h0;
    arrayCheck = 7'h0;
    upper = 16'h0000;
  end
  logic [15:0] upper;
  // Array word and check code as seen at the next read.
  task automatic load(input logic [31:0] d, input logic [6:0] c);
    arrayData <= d;
    arrayCheck <= c;
  endtask
  task automatic acc(input logic w, h, r, input logic [15:0] a, d);
    @(posedge ref_clk);
    busValid <= 1'b1;
    busWrite <= w;
    busHalf <= h;
    busInRange <= r;
    busAddr <= {upper, a};
    busWdata <= d;
  endtask
  // Released lines flip, so a stale value never passes for a command.
  task automatic idle();
    @(posedge ref_clk);
    busValid <= 1'b0;
    busAddr <= ~busAddr;
    busWdata <= ~busWdata;
  endtask
endmodule // mfcs_cpu_model
`default_nettype wire

/* File: verif/mfcs_sequencer_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// Mode, command and strobe relations seen at the sequencer ports.
module mfcs_sequencer_properties (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rst,
  // Width select.
  input wire logic        widthWrite,
  input wire logic [1:0]  widthIn,
  input wire logic [1:0]  access_width_field,
  input wire logic        fetchAllowed,
  // CPU bus.
  input wire logic        busValid,
  input wire logic        busWrite,
  input wire logic        busHalf,
  input wire logic        busInRange,
  input wire logic [31:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic        busError,
  // Algorithm strobes.
  input wire logic        progStart,
  input wire logic [15:0] program_half_word,
  input wire logic        chipEraseStart,
  input wire logic        eraseSuspend,
  input wire logic        eraseResume,
  input wire logic        busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Properties tie each strobe but sectorEraseStart to the access that caused it.
  property p_rst_rom; $fell(rst) |-> access_width_field == 2'h2; endproperty
  property p_wr_width;
    widthWrite |=> access_width_field == $past(widthIn);
  endproperty
  property p_fetch; fetchAllowed == (access_width_field == 2'h2); endproperty
  property p_rom_quiet;
    access_width_field == 2'h2 |-> !(progStart || chipEraseStart);
  endproperty
  property p_rom_err;
    busValid && busWrite && access_width_field == 2'h2 |=> busError;
  endproperty
  property p_word_err;
    busValid && !busWrite && !busHalf && access_width_field == 2'h1
      |=> busError;
  endproperty
  property p_prog;
    progStart |-> busInRange && busHalf && !busAddr[0]
      ##1 program_half_word == $past(busWdata) && busy;
  endproperty
  property p_chip;
    chipEraseStart |-> busWdata[7:0] == 8'h10 && busAddr[15:0] == 16'h1550;
  endproperty
  property p_susp;
    eraseSuspend |-> busWdata[7:0] == 8'hb0 && busy && busValid;
  endproperty
  property p_resume; eraseResume |-> busWdata[7:0] == 8'h30; endproperty

  a_rst_rom: assert property (p_rst_rom) else $error("width not rom");
  a_wr_width: assert property (p_wr_width) else $error("width load");
  a_fetch: assert property (p_fetch) else $error("fetch flag");
  a_rom_quiet: assert property (p_rom_quiet) else $error("rom start");
  a_rom_err: assert property (p_rom_err) else $error("rom write");
  a_word_err: assert property (p_word_err) else $error("word read");
  a_prog: assert property (p_prog) else $error("program start");
  a_chip: assert property (p_chip) else $error("chip erase");
  a_susp: assert property (p_susp) else $error("suspend");
  a_resume: assert property (p_resume) else $error("restart");

  c_prog: cover property (progStart);
  c_chip: cover property (chipEraseStart);
  c_resume: cover property (eraseResume);
endmodule // mfcs_sequencer_properties

bind mfcs_sequencer mfcs_sequencer_properties chk (.ref_clk, .rst,
  .widthWrite, .widthIn, .access_width_field, .fetchAllowed, .busValid,
  .busWrite, .busHalf, .busInRange, .busAddr, .busWdata, .busError,
  .progStart, .program_half_word, .chipEraseStart, .eraseSuspend,
  .eraseResume, .busy);
`default_nettype wire

/* File: verif/tb_main_flash_command_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_main_flash_command_sequencer;
  logic ref_clk, rst, widthWrite, algDone, algOverrun, fetchAllowed;
  logic busValid, busWrite, busHalf, busInRange, busError, busy;
  logic progStart, chipEraseStart, sectorEraseStart;
  logic eraseSuspend, eraseResume;
  logic [1:0] widthIn, access_width_field;
  logic [31:0] busAddr, arrayData, busRdata, progWord;
  logic [16:0] pta;
  logic [15:0] sectorMask;
  logic [15:0] busWdata, program_half_word, pd, ta;
  logic [6:0] arrayCheck;
  logic [5:0] ev, evExp;
  logic [5:0] q[$];
  int n_mismatch, tests_run, cyc;

  mfcs_cpu_model cpu (.ref_clk, .busValid, .busWrite, .busHalf,
    .busInRange, .busAddr, .busWdata, .arrayData, .arrayCheck);
  mfcs_sequencer #(.WINDOW_TICKS(8)) uut (.ref_clk, .rst, .widthWrite,
    .widthIn, .access_width_field, .fetchAllowed, .busValid, .busWrite,
    .busHalf, .busInRange, .busAddr, .busWdata, .busError, .busRdata,
    .arrayData, .arrayCheck, .arrayIndex(), .progStart,
    .program_target_address(pta), .program_half_word, .progWord,
    .progCheck(), .chipEraseStart, .sectorEraseStart, .sectorMask,
    .eraseSuspend, .eraseResume, .algDone, .algOverrun, .busy);

  // Free-running 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Each strobe or error takes the oldest note; none noted means zero.
  always @(posedge ref_clk) begin
    ev = {busError, progStart, chipEraseStart, sectorEraseStart,
          eraseSuspend, eraseResume};
    if (!rst && ev !== 6'h00) begin
      evExp = (q.size() > 0) ? q.pop_front() : 6'h00;
      check(ev, evExp, "event");
    end
  end

  // A hang is cut short well beyond the ninety or so cycles needed.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Random upper byte shows that only the low byte is compared.
  task automatic w(input logic [15:0] a, input logic [7:0] c);
    cpu.acc(1'b1, 1'b1, 1'b1, a, {8'($urandom), c});
  endtask
  task automatic unl();
    w(16'h1550, 8'haa);
    w(16'h0aa8, 8'h55);
  endtask
  task automatic done();
    @(posedge ref_clk);
    algDone <= 1'b1;
    @(posedge ref_clk);
    algDone <= 1'b0;
  endtask
  task automatic setw(input logic [1:0] v);
    @(posedge ref_clk);
    widthWrite <= 1'b1;
    widthIn <= v;
    @(posedge ref_clk);
    widthWrite <= 1'b0;
    #1;
  endtask
  task automatic prog();
    pd = 16'($urandom);
    ta = 16'($urandom) & 16'hfffe;
    unl();
    w(16'h1550, 8'ha0);
    q.push_back(6'h10);
    cpu.acc(1'b1, 1'b1, 1'b1, ta, pd);
    cpu.idle();
    #1;
  endtask

  initial begin
    rst = 1'b1;
    widthWrite = 1'b0;
    widthIn = 2'h0;
    algDone = 1'b0;
    algOverrun = 1'b0;
    cyc = 0;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(32'h114a));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(access_width_field, 2'h2, "width");
    check(fetchAllowed, 1'b1, "fetch");
    q.push_back(6'h20);
    w(16'h1550, 8'haa);
    cpu.idle();
    setw(2'h1);
    check(fetchAllowed, 1'b0, "fetch");
    $display("test rom mode done");
    prog();
    check(program_half_word, pd, "data");
    check(pta, {1'b0, ta}, "target");
    check(progWord, ta[1] ? {pd, 16'hffff} : {16'hffff, pd}, "word");
    check(busy, 1'b1, "busy");
    w(16'h0000, 8'hb0);
    cpu.idle();
    done();
    q.push_back(6'h20);
    // A zero word with data bit 0 flipped must read back corrected.
    cpu.load(32'h0000_0001, 7'h00);
    cpu.acc(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000);
    cpu.idle();
    #1;
    check(busRdata, 32'h0000_0000, "rdata");
    cpu.load(32'h0000_0000, 7'h00);
    $display("test program done");
    unl();
    w(16'h1550, 8'h80);
    unl();
    q.push_back(6'h08);
    w(16'h1550, 8'h10);
    cpu.idle();
    done();
    $display("test chip erase done");
    unl();
    w(16'h1550, 8'h80);
    unl();
    w(16'h4000, 8'h30);
    w(16'h8000, 8'h30);
    cpu.idle();
    q.push_back(6'h04);
    repeat (20) @(posedge ref_clk);
    #1;
    check(sectorMask, 32'h0000_0014, "mask");
    w(16'h0000, 8'h30);
    q.push_back(6'h02);
    w(16'h0000, 8'hb0);
    q.push_back(6'h01);
    w(16'h0000, 8'h30);
    cpu.idle();
    done();
    $display("test sector erase done");
    w(16'h1550, 8'haa);
    w(16'h1234, 8'h55);
    w(16'h1550, 8'ha0);
    w(16'h0100, 8'h00);
    unl();
    w(16'h0000, 8'hf0);
    w(16'h1550, 8'ha0);
    w(16'h0100, 8'h00);
    w(16'h0000, 8'h30);
    cpu.idle();
    repeat (2) @(posedge ref_clk);
    $display("test abandon done");
    cpu.upper = 16'h0010;
    prog();
    cpu.upper = 16'h0000;
    @(posedge ref_clk);
    algOverrun <= 1'b1;
    @(posedge ref_clk);
    algOverrun <= 1'b0;
    w(16'h0000, 8'hf0);
    cpu.idle();
    #1;
    check(busy, 1'b0, "busy");
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(access_width_field, 2'h2, "width");
    check(32'(q.size()), 32'h0, "pending");
    $display("test recovery done");
    stop_test();
  end
endmodule // tb_main_flash_command_sequencer
`default_nettype wire
